// ### rtl/tcc_consts.svh
/*
  constants for the timer channel capture/compare block: register offsets,
  field positions, reset values and interrupt bit positions.
  assumes inclusion by bare name from the design modules and the sim files.
*/
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

`define TCC_ADDR_W       3
`define TCC_OFS_SC       3'h0
`define TCC_OFS_VH       3'h1
`define TCC_OFS_VL       3'h2
`define TCC_OFS_IRQ_STAT 3'h3
`define TCC_OFS_IRQ_CLR  3'h4
`define TCC_OFS_IRQ_EN   3'h5
`define TCC_OFS_CNTRL    3'h6

`define TCC_SC_FLAG      7
`define TCC_SC_IE        6
`define TCC_SC_MSB       5
`define TCC_SC_MSA       4
`define TCC_SC_ELSB      3
`define TCC_SC_ELSA      2
`define TCC_CNTRL_CENTER_ALIGN_SELECT  0

`define TCC_SC_RESET     8'h00
`define TCC_VAL_RESET    16'h0000
`define TCC_IRQ_CAP      0
`define TCC_IRQ_MATCH    1
`define TCC_IRQ_BITS     2

`endif

// ### rtl/tcc_pkg.sv
/*
  types for the timer channel capture/compare block.
  assumes nothing beyond the constants header.
*/
package tcc_pkg;
  // channel function decoded from the mode, edge/level and center-align bits
  typedef enum logic [2:0] {
    TCC_FN_OFF    = 3'b000,
    TCC_FN_CAP    = 3'b001,
    TCC_FN_CMP    = 3'b010,
    TCC_FN_EPWM   = 3'b011,
    TCC_FN_CPWM   = 3'b100
  } tcc_fn_t;
endpackage : tcc_pkg

// ### rtl/tcc_pin_ctl.sv
/*
  pin action unit of the timer channel: edge detect on the input side and
  drive level on the output side.
  assumes the pin input is synchronous to clk and count steps are pulses.
*/
`timescale 1ns/100ps
`include "tcc_consts.svh"
module tcc_pin_ctl (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire tcc_pkg::tcc_fn_t fn,
  input  wire logic [1:0]      els,
  input  wire logic            pin_in,
  input  wire logic            match,
  input  wire logic            count_up,
  input  wire logic            period_wrap,
  output logic                 cap_edge,
  output logic                 pin_out,
  output logic                 pin_oe
);
  typedef struct packed {
    logic prev;
    logic drv;
  } tcc_pin_st_t;

  tcc_pin_st_t st_reg;
  tcc_pin_st_t st_next;

  // edges are seen against the previous sample, kept in every function; a pin
  // that moved before capture was entered does not show as an edge
  always_comb begin
    st_next = st_reg;
    st_next.prev = pin_in;
    cap_edge = 1'b0;
    if (fn == tcc_pkg::TCC_FN_CAP) begin
      unique case (els)
        2'b01:   cap_edge = pin_in & ~st_reg.prev;
        2'b10:   cap_edge = ~pin_in & st_reg.prev;
        2'b11:   cap_edge = pin_in ^ st_reg.prev;
        default: cap_edge = 1'b0;
      endcase
    end
    unique case (fn)
      tcc_pkg::TCC_FN_CMP: begin
        if (match) begin
          unique case (els)
            2'b01:   st_next.drv = ~st_reg.drv;
            2'b10:   st_next.drv = 1'b0;
            2'b11:   st_next.drv = 1'b1;
            default: st_next.drv = st_reg.drv;
          endcase
        end
      end
      tcc_pkg::TCC_FN_EPWM, tcc_pkg::TCC_FN_CPWM: begin
        // period start drives the active level; a match ends it, in center mode only while counting up
        if (period_wrap) begin
          st_next.drv = ~els[0];
        end
        if (match && (fn == tcc_pkg::TCC_FN_EPWM || count_up)) begin
          st_next.drv = els[0];
        end
      end
      default: st_next.drv = st_reg.drv;
    endcase
  end

  // pin released in off and capture functions
  assign pin_oe  = (fn != tcc_pkg::TCC_FN_OFF) &&
                   (fn != tcc_pkg::TCC_FN_CAP);
  assign pin_out = st_reg.drv;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : tcc_pin_ctl

// ### rtl/tcc_channel.sv
/*
  timer channel capture/compare top: register port, value buffers,
  channel flag and interrupt status.
  assumes the counter, its step pulse, direction and wrap come from outside.
*/
`timescale 1ns/100ps
`include "tcc_consts.svh"
module tcc_channel #(
  parameter int CNT_W = 16
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [`TCC_ADDR_W-1:0] addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wr_stb,
  input  wire logic                   rd_stb,
  output logic      [7:0]             rdata,
  input  wire logic [CNT_W-1:0]       counter,
  input  wire logic                   count_step,
  input  wire logic                   count_up,
  input  wire logic                   period_wrap,
  input  wire logic                   pin_in,
  output logic                        pin_out,
  output logic                        pin_oe,
  output logic                        irq
);
  typedef struct packed {
    logic [7:0]       sc;
    logic             center_align_select;
    logic [CNT_W-1:0] val;
    logic [CNT_W-1:0] rbuf;
    logic             rlatch;
    logic             rlatch_hi_first;
    logic [7:0]       wb_hi;
    logic [7:0]       wb_lo;
    logic             wb_hi_ok;
    logic             wb_lo_ok;
    logic             flag_armed;
    logic [`TCC_IRQ_BITS-1:0] istat;
    logic [`TCC_IRQ_BITS-1:0] ien;
    logic [7:0]       rdata;
  } tcc_st_t;

  tcc_st_t          st_reg;
  tcc_st_t          st_next;
  tcc_pkg::tcc_fn_t fn;
  logic             cap_edge;
  logic             match;
  logic             flag_evt;
  logic [1:0]       els;
  logic [1:0]       ms;

  assign els = st_reg.sc[`TCC_SC_ELSB:`TCC_SC_ELSA];
  assign ms  = st_reg.sc[`TCC_SC_MSB:`TCC_SC_MSA];

  // function decode; field 00 wins over every other setting
  always_comb begin
    if (els == 2'b00) begin
      fn = tcc_pkg::TCC_FN_OFF;
    end else if (st_reg.center_align_select) begin
      fn = tcc_pkg::TCC_FN_CPWM;
    end else if (ms == 2'b00) begin
      fn = tcc_pkg::TCC_FN_CAP;
    end else if (ms == 2'b01) begin
      fn = tcc_pkg::TCC_FN_CMP;
    end else begin
      fn = tcc_pkg::TCC_FN_EPWM;
    end
  end

  // software-only compare still matches even though els reads 00
  logic cmp_mode;
  assign cmp_mode = st_reg.center_align_select || (ms != 2'b00);
  assign match = count_step && cmp_mode &&
                 (counter == st_reg.val);

  tcc_pin_ctl u_pin (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .fn          (fn),
    .els         (els),
    .pin_in      (pin_in),
    .match       (match),
    .count_up    (count_up),
    .period_wrap (period_wrap),
    .cap_edge    (cap_edge),
    .pin_out     (pin_out),
    .pin_oe      (pin_oe)
  );

  // flag sources: center PWM sets it on every match as well
  assign flag_evt = cap_edge | match;

  logic [CNT_W-1:0] rd_src;

  // frozen copy while latched, live value otherwise
  assign rd_src = st_reg.rlatch ? st_reg.rbuf : st_reg.val;

  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;

    // capture loads the channel value directly
    if (fn == tcc_pkg::TCC_FN_CAP && cap_edge) begin
      st_next.val = counter;
    end

    // register writes
    if (wr_stb) begin
      unique case (addr)
        `TCC_OFS_SC: begin
          st_next.sc[`TCC_SC_IE:0] = wdata[`TCC_SC_IE:0];
          // writing 1 to the flag is ignored; 0 clears only when armed
          if (!wdata[`TCC_SC_FLAG] && st_reg.flag_armed) begin
            st_next.sc[`TCC_SC_FLAG] = 1'b0;
          end
          st_next.flag_armed = 1'b0;
          st_next.rlatch   = 1'b0;
          st_next.wb_hi_ok = 1'b0;
          st_next.wb_lo_ok = 1'b0;
        end
        `TCC_OFS_VH: begin
          if (fn != tcc_pkg::TCC_FN_CAP) begin
            st_next.wb_hi    = wdata;
            st_next.wb_hi_ok = 1'b1;
          end
        end
        `TCC_OFS_VL: begin
          if (fn != tcc_pkg::TCC_FN_CAP) begin
            st_next.wb_lo    = wdata;
            st_next.wb_lo_ok = 1'b1;
          end
        end
        `TCC_OFS_IRQ_CLR: begin
          st_next.istat = st_reg.istat & ~wdata[`TCC_IRQ_BITS-1:0];
        end
        `TCC_OFS_IRQ_EN: begin
          st_next.ien = wdata[`TCC_IRQ_BITS-1:0];
        end
        `TCC_OFS_CNTRL: begin
          st_next.center_align_select = wdata[`TCC_CNTRL_CENTER_ALIGN_SELECT];
        end
        default: begin
        end
      endcase
    end

    // both halves in: one-step transfer of the whole word
    if (st_next.wb_hi_ok && st_next.wb_lo_ok) begin
      st_next.val = {st_next.wb_hi, st_next.wb_lo};
      st_next.wb_hi_ok = 1'b0;
      st_next.wb_lo_ok = 1'b0;
    end

    // register reads, data one cycle later
    if (rd_stb) begin
      unique case (addr)
        `TCC_OFS_SC: begin
          st_next.rdata = st_reg.sc;
          if (st_reg.sc[`TCC_SC_FLAG]) begin
            st_next.flag_armed = 1'b1;
          end
        end
        `TCC_OFS_VH, `TCC_OFS_VL: begin
          st_next.rdata = (addr == `TCC_OFS_VH) ? rd_src[15:8]
                                                : rd_src[7:0];
          if (fn == tcc_pkg::TCC_FN_CAP) begin
            // first read freezes, read of the other byte releases;
            // a repeat read of the same byte keeps it frozen
            if (!st_reg.rlatch) begin
              st_next.rlatch = 1'b1;
              st_next.rbuf   = st_reg.val;
              st_next.rlatch_hi_first = (addr == `TCC_OFS_VH);
            end else if ((addr == `TCC_OFS_VH) !=
                         st_reg.rlatch_hi_first) begin
              st_next.rlatch = 1'b0;
            end
          end
        end
        `TCC_OFS_IRQ_STAT: st_next.rdata = {6'h00, st_reg.istat};
        `TCC_OFS_IRQ_EN:   st_next.rdata = {6'h00, st_reg.ien};
        `TCC_OFS_CNTRL:    st_next.rdata = {7'h00, st_reg.center_align_select};
        default:           st_next.rdata = 8'h00;
      endcase
    end

    // events last so a set beats a clear in the same cycle
    if (flag_evt) begin
      st_next.sc[`TCC_SC_FLAG] = 1'b1;
      st_next.flag_armed = 1'b0;
    end
    if (cap_edge) begin
      st_next.istat[`TCC_IRQ_CAP] = 1'b1;
    end
    if (match) begin
      st_next.istat[`TCC_IRQ_MATCH] = 1'b1;
    end
  end

  assign rdata = st_reg.rdata;
  // channel flag request or gated sticky status
  assign irq = (st_reg.sc[`TCC_SC_FLAG] & st_reg.sc[`TCC_SC_IE]) |
               (|(st_reg.istat & st_reg.ien));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg     <= '0;
      st_reg.sc  <= `TCC_SC_RESET;
      st_reg.val <= `TCC_VAL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : tcc_channel

// ### sim/tcc_channel_properties.sv
/* port checker for the channel top.
   assumes a bind to every tcc_channel instance. */
`timescale 1ns/100ps
`include "tcc_consts.svh"
module tcc_props (
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire logic [`TCC_ADDR_W-1:0] addr,
  input wire logic [7:0]             wdata,
  input wire logic                   wr_stb,
  input wire logic                   rd_stb,
  input wire logic [7:0]             rdata,
  input wire logic                   count_step,
  input wire logic                   period_wrap,
  input wire logic                   pin_in,
  input wire logic                   pin_out,
  input wire logic                   pin_oe,
  input wire logic                   irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [2:0] bus_q;
  logic [2:0] pin_q;
  wire logic  sc_wr = wr_stb && addr == `TCC_OFS_SC;
  // recent causes; edge detect may lag the pin by two cycles
  always_ff @(posedge clk) begin
    bus_q <= {bus_q[1:0], count_step | period_wrap | wr_stb};
    pin_q <= {pin_q[1:0], pin_in};
  end
  a_rdata_idle: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_rd: assert property (rd_stb && addr == 3'h7 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_oe_release: assert property (
    sc_wr && wdata[3:2] == 2'h0 |=> !pin_oe)
    else $error("pin still driven with edge level 00");
  a_oe_drive: assert property (
    sc_wr && wdata[5:4] != 2'h0 && wdata[3:2] != 2'h0 |=> pin_oe)
    else $error("pin not driven in compare or pwm");
  a_oe_cause: assert property ($changed(pin_oe) |-> $past(wr_stb))
    else $error("pin enable moved without a write");
  a_pin_cause: assert property ($changed(pin_out) |-> |bus_q[1:0])
    else $error("pin level moved without a cause");
  a_irq_cause: assert property (
    $rose(irq) |-> |bus_q || pin_q[2] != pin_q[0])
    else $error("interrupt rose without an event");
  a_reset_clean: assert property (
    $fell(sys_rst) |-> rdata == 8'h00 && !pin_oe && !pin_out && !irq)
    else $error("outputs not idle after reset");
  c_sc_write: cover property (sc_wr);
  c_irq_rise: cover property ($rose(irq));
  c_pin_move: cover property ($changed(pin_out));
endmodule : tcc_props
bind tcc_channel tcc_props u_props (.clk(clk), .sys_rst(sys_rst),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .count_step(count_step), .period_wrap(period_wrap),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));

// ### sim/tcc_pin_src.sv
/* model of the signal source on the channel pin.
   assumes requests are one-cycle pulses on clk. */
`timescale 1ns/100ps
module tcc_pin_src (
  input wire logic       clk,
  input wire logic       req,
  input wire logic       lvl,
  input wire logic [3:0] dly,
  output logic           pin
);
  logic [3:0] cnt_reg;
  logic       lvl_reg;
  logic       busy_reg = 1'h0;
  initial pin = 1'h0;
  // level moves after a chosen delay, then holds until the next request
  always @(posedge clk) begin
    if (req) begin
      busy_reg <= 1'h1;
      cnt_reg  <= dly;
      lvl_reg  <= lvl;
    end else if (busy_reg && cnt_reg == 4'h0) begin
      pin      <= lvl_reg;
      busy_reg <= 1'h0;
    end else if (busy_reg) cnt_reg <= cnt_reg - 4'h1;
  end
endmodule : tcc_pin_src

// ### sim/timer_channel_capture_compare_bench.sv
/* self-checking bench for the channel: register port and pin source.
   assumes design, pin model and checker are compiled first. */
`timescale 1ns/100ps
`include "tcc_consts.svh"
module timer_channel_capture_compare_bench;
  logic        clk, sys_rst, wr_stb, rd_stb, count_step, count_up;
  logic        period_wrap, req, lvl, pin_in, pin_out, pin_oe, irq, ep;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, d;
  logic [15:0] counter, v, c, cur, e;
  logic [3:0]  dly;
  logic [31:0] seed = 32'h000054FB;
  int          errors = 0, n_compared = 0, cyc = 0;
  tcc_channel DUT (.clk(clk), .sys_rst(sys_rst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .counter(counter), .count_step(count_step), .count_up(count_up),
    .period_wrap(period_wrap), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq(irq));
  tcc_pin_src u_pin (.clk(clk), .req(req), .lvl(lvl), .dly(dly),
    .pin(pin_in));
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd
  // pin after a compare match for each edge/level code
  function automatic logic cmp_pin(input logic [1:0] els, input logic p);
    case (els)
      2'h1: return !p;
      2'h2: return 1'h0;
      2'h3: return 1'h1;
      default: return p;
    endcase
  endfunction : cmp_pin
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr_stb <= 1'h1;
    @(posedge clk);
    wr_stb <= 1'h0;
  endtask : wr
  // data stand only in the cycle after the strobe
  task automatic rchk(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'h1;
    @(posedge clk);
    rd_stb <= 1'h0;
    #1 chk(rdata, x);
  endtask : rchk
  task automatic step(input logic [15:0] cv, input logic w);
    @(posedge clk);
    counter <= cv;
    count_step <= !w;
    period_wrap <= w;
    @(posedge clk);
    count_step <= 1'h0;
    period_wrap <= 1'h0;
    repeat (3) @(posedge clk);
  endtask : step
  task automatic edge_to(input logic l);
    @(posedge clk);
    req <= 1'h1;
    lvl <= l;
    dly <= 4'(rnd() & 16'h0003);
    @(posedge clk);
    req <= 1'h0;
    repeat (10) @(posedge clk);
  endtask : edge_to
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the roughly 500 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    {addr, wdata, wr_stb, rd_stb, counter, count_step} = '0;
    {period_wrap, req, lvl, dly, ep, cur} = '0;
    count_up = 1'h1;
    sys_rst = 1'h1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    for (int a = 0; a < 8; a++) if (a != 4) rchk(3'(a), 8'h00);
    // compare value in both byte orders, old value until the pair completes
    wr(0, 8'h14);
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      if (i[0]) wr(1, v[15:8]);
      else wr(2, v[7:0]);
      rchk(1, cur[15:8]);
      if (i[0]) wr(2, v[7:0]);
      else wr(1, v[15:8]);
      rchk(1, v[15:8]);
      rchk(2, v[7:0]);
      cur = v;
    end
    wr(1, 8'hA5);
    wr(0, 8'h14);
    wr(2, 8'h5A);
    rchk(1, cur[15:8]);
    // every compare action, flag set and cleared by read then write
    for (int k = 0; k < 4; k++) begin
      wr(0, {4'h1, 2'(k), 2'h0});
      step(cur, 1'h0);
      ep = (k == 0) ? ep : cmp_pin(2'(k), ep);
      chk({7'h00, pin_oe}, {7'h00, k != 0});
      if (k != 0) chk({7'h00, pin_out}, {7'h00, ep});
      rchk(0, {4'h9, 2'(k), 2'h0});
      wr(0, {4'h1, 2'(k), 2'h0});
      step(cur + 16'h0001, 1'h0);
      rchk(0, {4'h1, 2'(k), 2'h0});
    end
    // writing 1 keeps the flag; an event between read and write keeps it
    wr(0, 8'h10);
    step(cur, 1'h0);
    rchk(0, 8'h90);
    wr(0, 8'h90);
    rchk(0, 8'h90);
    step(cur, 1'h0);
    wr(0, 8'h10);
    rchk(0, 8'h90);
    wr(0, 8'h10);
    rchk(0, 8'h10);
    rchk(3, 8'h02);
    // irq comes from a register: look after the edge has settled
    wr(5, 8'h02);
    #1 chk({7'h00, irq}, 8'h01);
    wr(5, 8'h00);
    #1 chk({7'h00, irq}, 8'h00);
    wr(4, 8'h02);
    rchk(3, 8'h00);
    // edge then center pwm, both pulse polarities
    for (int cp = 0; cp < 2; cp++) for (int j = 1; j < 3; j++) begin
      wr(6, 8'(cp));
      wr(0, {4'h2, 2'(j), 2'h0});
      step(cur, 1'h1);
      chk({7'h00, pin_out}, {7'h00, j == 2});
      step(cur, 1'h0);
      chk({7'h00, pin_out}, {7'h00, j != 2});
      // center mode: a down-count match must leave the active level
      if (cp == 1) begin
        step(cur, 1'h1);
        count_up <= 1'h0;
        step(cur, 1'h0);
        count_up <= 1'h1;
        chk({7'h00, pin_out}, {7'h00, j == 2});
      end
    end
    wr(6, 8'h00);
    // capture each edge code, frozen pair, release by a status write
    for (int k = 1; k < 4; k++) begin
      wr(0, {4'h0, 2'(k), 2'h0});
      c = rnd();
      counter <= c;
      edge_to(1'h1);
      v = rnd();
      counter <= v;
      edge_to(1'h0);
      e = (k == 1) ? c : v;
      rchk(1, e[15:8]);
      c = rnd();
      counter <= c;
      edge_to(1'h1);
      rchk(2, e[7:0]);
      e = (k == 2) ? e : c;
      rchk(1, e[15:8]);
      wr(0, {4'h0, 2'(k), 2'h0});
      v = rnd();
      counter <= v;
      edge_to(1'h0);
      e = (k == 1) ? e : v;
      rchk(2, e[7:0]);
      rchk(1, e[15:8]);
    end
    wr(0, 8'h00);
    rchk(3, 8'h03);
    // flag left set by the captures, now routed to the interrupt
    wr(0, 8'h40);
    #1 chk({7'h00, irq}, 8'h01);
    rchk(0, 8'hC0);
    wr(0, 8'h40);
    #1 chk({7'h00, irq}, 8'h00);
    report_and_stop();
  end
endmodule : timer_channel_capture_compare_bench
